/* File: logic/snv_pkg.sv */
/*
  snv_pkg: shared constants and types of the serial nonvolatile memory slave.
  assumes: used by snv_slave, referenced only through snv_pkg::name.
*/
`default_nettype none
package snv_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int ADDR_HI_W = ADDR_W - DATA_W;
  localparam int BUF_DEPTH = 2;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // opcodes
  localparam logic [7:0] OP_ARM = 8'h06;
  localparam logic [7:0] OP_DISARM = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_MEM_RD = 8'h03;
  localparam logic [7:0] OP_MEM_WR = 8'h02;
  // protection_status fields
  localparam int PIN_GUARD_ENABLE = 7;
  localparam int BLOCK_GUARD_HI = 3;
  localparam int BLOCK_GUARD_LO = 2;
  localparam int WRITE_ARM_LATCH = 1;
  localparam int STAT_NV_LSB = 2;
  localparam logic [7:0] STAT_RESET = 8'h00;
  // block guard lower bounds
  localparam logic [ADDR_W-1:0] GUARD_QUARTER = 13'h1800;
  localparam logic [ADDR_W-1:0] GUARD_HALF = 13'h1000;
  typedef enum logic [2:0] {
    PH_OPCODE, PH_ADDR_HI, PH_ADDR_LO, PH_WDATA, PH_RDATA, PH_STAT_RD, PH_STAT_WR, PH_IDLE
  } snv_phase_t;
  typedef logic [ADDR_W+DATA_W-1:0] snv_word_t;
endpackage
`default_nettype wire

/* File: logic/snv_mem.sv */
/*
  snv_mem: single-port array with registered read data.
  assumes: a read and a write are never requested in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module snv_mem #(
  parameter int AW = 13,
  parameter int DW = 8
) (
  // clock
  input wire logic clk,
  // access
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wr_data,
  output logic [DW-1:0] rd_data_ff
);
  logic [DW-1:0] cells [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      cells[addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data_ff <= cells[addr];
    end
  end
endmodule // snv_mem
`default_nettype wire

/* File: logic/snv_slave.sv */
/*
  snv_slave: serial slave of an 8K x 8 nonvolatile memory with its protection_status register.
  assumes: all pins are asynchronous to SYS_CLK and are synchronised here; the link clock
  runs at most one eighth of SYS_CLK so every edge is seen.
*/
// Contract
// - chip select high means standby, output floated, other inputs ignored.
// - pause low suspends transfer, floats output, ignores clock and data.
// - input sampled on rising clock edge, output changed on falling edge.
// - array data and status contents both come out on the output.
// - both mode 0 and mode 3 transfers work.
// - bit 7 pin guard enable, stored, writable, gates status writes with pin.
// - bits 6 to 4 are stored spare bits, writable, readable, start zero.
// - bits 3 and 2 choose the guarded array region, writable and readable.
// - bit 1 write arm latch: set by arm, cleared by disarm, not written.
// - arm latch cleared at power-on, disarm, and chip select rise after writes.
// - bit 0 reads zero always.
// - array writes need no busy time.
// - eight-bit opcodes; chip select rising mid-opcode drops the command.
// - 16-bit address, top 3 ignored, bytes stream with wrapping increment.
// - guard codes protect none, upper quarter, upper half, or all.
// - arm latch clear blocks all writes; status needs pin unless guard off.
`timescale 1ns/1ps
`default_nettype none
module snv_slave #(
  parameter int AW = snv_pkg::ADDR_W
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // serial link pins
  input wire logic CHIP_SEL_N,
  input wire logic SER_CLK,
  input wire logic SER_IN,
  input wire logic PAUSE_N,
  input wire logic WR_GUARD_N,
  output logic SER_OUT,
  output logic SER_OUT_OE
);
  if (AW != snv_pkg::ADDR_W) begin : g_chk
    $error("snv_slave: guard ranges assume a 13-bit address");
  end

  typedef struct packed {
    logic cs_m, cs_q, cs_p;
    logic sck_m, sck_q, sck_p;
    logic si_m, si_q;
    logic hold_m, hold_q;
    logic wp_m, wp_q;
    snv_pkg::snv_phase_t ph;
    logic is_rd;
    logic [2:0] bcnt;
    logic [6:0] sh_in;
    logic [AW-1:0] addr;
    logic [7:0] out_sr;
    logic so_live;
    logic so;
    logic oe;
    logic [7:0] stat;
    logic arm_clr;
    logic mem_re;
    logic [AW-1:0] re_addr;
    logic pend;
    snv_pkg::snv_word_t pend_word;
    logic [snv_pkg::BUF_DEPTH-1:0][AW+7:0] fifo;
    logic [1:0] cnt;
  } snv_state_t;

  snv_state_t s_ff, nxt_s;
  logic [7:0] rd_data;
  logic fifo_pop;
  logic [AW-1:0] mem_addr;

  function automatic logic guarded(input logic [1:0] bp, input logic [AW-1:0] a);
    case (bp)
      2'b01: guarded = (a >= snv_pkg::GUARD_QUARTER);
      2'b10: guarded = (a >= snv_pkg::GUARD_HALF);
      2'b11: guarded = 1'b1;
      default: guarded = 1'b0;
    endcase
  endfunction

  function automatic logic read_phase(input snv_pkg::snv_phase_t p);
    read_phase = (p == snv_pkg::PH_RDATA) || (p == snv_pkg::PH_STAT_RD);
  endfunction

  // reads outrank buffered writes on the single port; the buffer absorbs the stall
  assign fifo_pop = (s_ff.cnt != 2'd0) && !s_ff.mem_re;
  assign mem_addr = s_ff.mem_re ? s_ff.re_addr : s_ff.fifo[0][AW+7:8];

  snv_mem #(.AW(AW), .DW(snv_pkg::DATA_W)) u_mem (
    .clk(SYS_CLK),
    .rd_en(s_ff.mem_re),
    .wr_en(fifo_pop),
    .addr(mem_addr),
    .wr_data(s_ff.fifo[0][7:0]),
    .rd_data_ff(rd_data)
  );

  always_comb begin
    logic [7:0] b;
    logic [7:0] src;
    logic rise;
    logic fall;
    b = 8'h00;
    src = 8'h00;
    rise = s_ff.sck_q && !s_ff.sck_p;
    fall = !s_ff.sck_q && s_ff.sck_p;
    nxt_s = s_ff;
    // two-stage synchronisers, third stage for edges
    nxt_s.cs_m = CHIP_SEL_N;
    nxt_s.cs_q = s_ff.cs_m;
    nxt_s.cs_p = s_ff.cs_q;
    nxt_s.sck_m = SER_CLK;
    nxt_s.sck_q = s_ff.sck_m;
    nxt_s.sck_p = s_ff.sck_q;
    nxt_s.si_m = SER_IN;
    nxt_s.si_q = s_ff.si_m;
    nxt_s.hold_m = PAUSE_N;
    nxt_s.hold_q = s_ff.hold_m;
    nxt_s.wp_m = WR_GUARD_N;
    nxt_s.wp_q = s_ff.wp_m;
    nxt_s.mem_re = 1'b0;

    // write buffer: drain, then accept the pending byte when there is room
    if (fifo_pop) begin
      nxt_s.fifo[0] = s_ff.fifo[1];
      nxt_s.cnt = s_ff.cnt - 2'd1;
    end
    if (s_ff.pend && (nxt_s.cnt < 2'(snv_pkg::BUF_DEPTH))) begin
      nxt_s.fifo[nxt_s.cnt[0]] = s_ff.pend_word;
      nxt_s.cnt = nxt_s.cnt + 2'd1;
      nxt_s.pend = 1'b0;
    end

    if (s_ff.cs_q) begin
      // deselected: standby, every other pin ignored
      nxt_s.ph = snv_pkg::PH_OPCODE;
      nxt_s.bcnt = 3'd0;
      nxt_s.oe = 1'b0;
      nxt_s.so_live = 1'b0;
      if (!s_ff.cs_p) begin
        if (s_ff.arm_clr) begin
          nxt_s.stat[snv_pkg::WRITE_ARM_LATCH] = 1'b0;
        end
        nxt_s.arm_clr = 1'b0;
      end
    end else if (!s_ff.hold_q) begin
      nxt_s.oe = 1'b0;
    end else begin
      nxt_s.oe = s_ff.so_live && read_phase(s_ff.ph);
      if (rise) begin
        // same edge in mode 0 and mode 3: idle level never matters
        b = {s_ff.sh_in, s_ff.si_q};
        nxt_s.sh_in = b[6:0];
        nxt_s.bcnt = s_ff.bcnt + 3'd1;
        if (s_ff.bcnt == snv_pkg::BIT_LAST) begin
          case (s_ff.ph)
            snv_pkg::PH_OPCODE: begin
              nxt_s.ph = snv_pkg::PH_IDLE;
              case (b)
                snv_pkg::OP_ARM: nxt_s.stat[snv_pkg::WRITE_ARM_LATCH] = 1'b1;
                snv_pkg::OP_DISARM: nxt_s.stat[snv_pkg::WRITE_ARM_LATCH] = 1'b0;
                snv_pkg::OP_STAT_RD: nxt_s.ph = snv_pkg::PH_STAT_RD;
                snv_pkg::OP_STAT_WR: begin
                  nxt_s.ph = snv_pkg::PH_STAT_WR;
                  nxt_s.arm_clr = 1'b1;
                end
                snv_pkg::OP_MEM_RD: begin
                  nxt_s.ph = snv_pkg::PH_ADDR_HI;
                  nxt_s.is_rd = 1'b1;
                end
                snv_pkg::OP_MEM_WR: begin
                  nxt_s.ph = snv_pkg::PH_ADDR_HI;
                  nxt_s.is_rd = 1'b0;
                  nxt_s.arm_clr = 1'b1;
                end
                default: nxt_s.ph = snv_pkg::PH_IDLE;
              endcase
            end
            snv_pkg::PH_ADDR_HI: begin
              // upper three address bits are dropped
              nxt_s.addr[AW-1:8] = b[snv_pkg::ADDR_HI_W-1:0];
              nxt_s.ph = snv_pkg::PH_ADDR_LO;
            end
            snv_pkg::PH_ADDR_LO: begin
              nxt_s.addr[7:0] = b;
              nxt_s.ph = s_ff.is_rd ? snv_pkg::PH_RDATA : snv_pkg::PH_WDATA;
              nxt_s.mem_re = s_ff.is_rd;
              nxt_s.re_addr = {s_ff.addr[AW-1:8], b};
            end
            snv_pkg::PH_WDATA: begin
              if (s_ff.stat[snv_pkg::WRITE_ARM_LATCH] &&
                  !guarded(s_ff.stat[snv_pkg::BLOCK_GUARD_HI:snv_pkg::BLOCK_GUARD_LO],
                    s_ff.addr)) begin
                nxt_s.pend = 1'b1;
                nxt_s.pend_word = {s_ff.addr, b};
              end
              nxt_s.addr = s_ff.addr + AW'(1);
            end
            snv_pkg::PH_RDATA: begin
              // fetch the next byte early; it is needed at the next falling edge
              nxt_s.addr = s_ff.addr + AW'(1);
              nxt_s.mem_re = 1'b1;
              nxt_s.re_addr = s_ff.addr + AW'(1);
            end
            snv_pkg::PH_STAT_WR: begin
              nxt_s.ph = snv_pkg::PH_IDLE;
              if (s_ff.stat[snv_pkg::WRITE_ARM_LATCH] &&
                  !(s_ff.stat[snv_pkg::PIN_GUARD_ENABLE] && !s_ff.wp_q)) begin
                // bits 1 and 0 are never taken from the serial data
                nxt_s.stat[7:snv_pkg::STAT_NV_LSB] = b[7:snv_pkg::STAT_NV_LSB];
              end
            end
            default: nxt_s.ph = s_ff.ph;
          endcase
        end
      end
      if (fall && read_phase(s_ff.ph)) begin
        src = (s_ff.ph == snv_pkg::PH_STAT_RD) ? {s_ff.stat[7:1], 1'b0} : rd_data;
        nxt_s.so_live = 1'b1;
        nxt_s.oe = 1'b1;
        if (s_ff.bcnt == 3'd0) begin
          nxt_s.so = src[7];
          nxt_s.out_sr = {src[6:0], 1'b0};
        end else begin
          nxt_s.so = s_ff.out_sr[7];
          nxt_s.out_sr = {s_ff.out_sr[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      s_ff <= '0;
      s_ff.cs_m <= 1'b1;
      s_ff.cs_q <= 1'b1;
      s_ff.cs_p <= 1'b1;
      s_ff.hold_m <= 1'b1;
      s_ff.hold_q <= 1'b1;
      s_ff.wp_m <= 1'b1;
      s_ff.wp_q <= 1'b1;
      s_ff.ph <= snv_pkg::PH_OPCODE;
      s_ff.stat <= snv_pkg::STAT_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign SER_OUT = s_ff.so;
  assign SER_OUT_OE = s_ff.oe;
endmodule // snv_slave
`default_nettype wire

/* File: bench/snv_slave_properties.sv */
/* snv_slave_properties: port checks of snv_slave.
   assumes: bound to snv_slave; link clock at most SYS_CLK/8. */
`timescale 1ns/1ps
`default_nettype none
module snv_slave_properties (
  // clock, reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // link
  input wire logic CHIP_SEL_N,
  input wire logic SER_CLK,
  input wire logic PAUSE_N,
  input wire logic SER_OUT,
  input wire logic SER_OUT_OE
);
  logic sck_ff;
  logic [3:0] fall_ff;
  logic [3:0] rise_ff;
  logic hit;
  // raw pin edges; the design sees them 2-3 cycles later, hence the slack
  assign hit = !sck_ff && SER_CLK && PAUSE_N && rise_ff != 4'hf;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sck_ff <= 1'b0;
      fall_ff <= 4'hf;
      rise_ff <= 4'h0;
    end else begin
      sck_ff <= SER_CLK;
      fall_ff <= (sck_ff && !SER_CLK) ? 4'h0 : fall_ff + {3'h0, fall_ff != 4'hf};
      rise_ff <= CHIP_SEL_N ? 4'h0 : rise_ff + {3'h0, hit};
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence s_idle;
    CHIP_SEL_N [*5];
  endsequence
  sequence s_held;
    !PAUSE_N [*5] ##0 !CHIP_SEL_N;
  endsequence
  sequence s_high;
    SER_CLK [*4] ##0 SER_OUT_OE;
  endsequence
  AST_IDLE: assert property (s_idle |-> !SER_OUT_OE) else $error("oe idle");
  AST_CS_RISE: assert property ($rose(CHIP_SEL_N) |-> ##[1:6] !SER_OUT_OE) else $error("oe kept");
  AST_HELD: assert property (s_held |-> !SER_OUT_OE) else $error("oe paused");
  AST_HOLD_IN: assert property ($fell(PAUSE_N) |-> ##[1:6] !SER_OUT_OE) else $error("slow");
  AST_ON_FALL: assert property (SER_OUT_OE && $past(SER_OUT_OE) && $changed(SER_OUT)
    |-> fall_ff <= 4'h7) else $error("late shift");
  AST_STILL: assert property (s_high |-> $stable(SER_OUT)) else $error("shift high");
  AST_OE_SEL: assert property ($rose(SER_OUT_OE) |-> !CHIP_SEL_N && PAUSE_N) else $error("oe");
  AST_OPC: assert property (SER_OUT_OE && !CHIP_SEL_N |-> rise_ff >= 4'h8) else $error("early");
endmodule // snv_slave_properties
bind snv_slave snv_slave_properties i_props (.SYS_CLK(SYS_CLK), .RST(RST), .CHIP_SEL_N(CHIP_SEL_N),
  .SER_CLK(SER_CLK), .PAUSE_N(PAUSE_N), .SER_OUT(SER_OUT), .SER_OUT_OE(SER_OUT_OE));
`default_nettype wire

/* File: bench/snv_master_model.sv */
/* snv_master_model: serial bus master, mode 0 or 3, with pause.
   assumes: sys_clk is the design clock; moves only on its falling edge. */
`timescale 1ns/1ps
`default_nettype none
module snv_master_model (
  // clock
  input wire logic sys_clk,
  // link
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic pause_n,
  input wire logic so,
  // received byte
  output logic [7:0] rx,
  output logic rx_stb
);
  logic cpol;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    pause_n = 1'b1;
    rx = 8'h00;
    rx_stb = 1'b0;
    cpol = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // idle level set before select; select before the first bit
  task automatic sel();
    sck = cpol;
    cyc(2);
    cs_n = 1'b0;
    cyc(4);
  endtask
  task automatic desel();
    // back to the idle level before select rises
    sck = cpol;
    cyc(2);
    cs_n = 1'b1;
    si = ~si;
    cyc(6);
  endtask
  // msb first; drive on fall, capture on rise
  task automatic xb(input logic [7:0] b, input int n, input bit chk, input bit hold);
    for (int i = 7; i > 7 - n; i--) begin
      sck = 1'b0;
      si = b[i];
      cyc(5);
      sck = 1'b1;
      rx[i] = so;
      cyc(3);
      if (hold && i == 4) begin
        pause_n = 1'b0; // select held, clock level same on exit
        cyc(6);
        sck = 1'b0;
        si = ~si;
        cyc(6);
        sck = 1'b1;
        cyc(6);
        pause_n = 1'b1;
        cyc(4);
      end
    end
    if (chk) begin
      rx_stb = 1'b1;
      cyc(1);
      rx_stb = 1'b0;
    end
  endtask
endmodule // snv_master_model
`default_nettype wire

/* File: bench/snv_slave_tb.sv */
/* snv_slave_tb: self-checking bench of snv_slave.
   assumes: snv_master_model as the bus master. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch %0t got %h exp %h", $time, a, e); end end
module snv_slave_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wg_n = 1'b1;
  logic [7:0] e;
  logic [7:0] d [6];
  logic [7:0] exp_q [$];
  int n_fail = 0;
  int n_checks = 0;
  int seed = 38304;
  wire logic cs_n, sck, si, pz_n, so_d, oe, so_w, stb;
  wire logic [7:0] rx;
  always #25 clk = ~clk;
  // released line shows the inverse of its last level, so a late enable is caught
  assign so_w = oe ? so_d : ~so_d;
  snv_slave i_dut (.SYS_CLK(clk), .RST(rst), .CHIP_SEL_N(cs_n), .SER_CLK(sck), .SER_IN(si),
    .PAUSE_N(pz_n), .WR_GUARD_N(wg_n), .SER_OUT(so_d), .SER_OUT_OE(oe));
  snv_master_model i_mst (.sys_clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .pause_n(pz_n),
    .so(so_w), .rx(rx), .rx_stb(stb));
  task automatic hdr(input logic [7:0] op, input logic [15:0] a, input bit wa);
    i_mst.sel();
    i_mst.xb(op, 8, 0, 0);
    if (wa) i_mst.xb(a[15:8], 8, 0, 0);
    if (wa) i_mst.xb(a[7:0], 8, 0, 0);
  endtask
  task automatic rdb(input logic [7:0] x, input bit h);
    exp_q.push_back(x);
    i_mst.xb(8'h00, 8, 1, h);
  endtask
  task automatic op1(input logic [7:0] op, input logic [7:0] v, input bit wv);
    hdr(op, 16'h0000, 0);
    if (wv) i_mst.xb(v, 8, 0, 0);
    i_mst.desel();
  endtask
  task automatic srd(input logic [7:0] x, input bit h);
    hdr(8'h05, 16'h0000, 0);
    rdb(x, h);
    i_mst.desel();
  endtask
  task automatic mwr(input logic [15:0] a, input logic [7:0] v0, input logic [7:0] v1);
    hdr(8'h02, a, 1);
    i_mst.xb(v0, 8, 0, 0);
    i_mst.xb(v1, 8, 0, 0);
    i_mst.desel();
  endtask
  task automatic mrd(input logic [15:0] a, input logic [7:0] x0, input logic [7:0] x1, input int n);
    hdr(8'h03, a, 1);
    rdb(x0, 0);
    if (n > 1) rdb(x1, 0);
    i_mst.desel();
  endtask
  task automatic stop_test();
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge stb) begin
    e = exp_q.pop_front();
    `CHK(rx, e)
  end
  initial begin
    repeat (50000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 6; i++) d[i] = 8'($random(seed));
    srd(8'h00, 0);
    op1(8'h01, 8'hf6, 1);
    srd(8'h00, 0);
    op1(8'h06, 8'h00, 0);
    srd(8'h02, 0);
    mwr(16'hffff, d[0], d[1]);
    i_mst.cpol = 1'b1;
    mrd(16'he000 | 16'h1fff, d[0], d[1], 2);
    i_mst.cpol = 1'b0;
    srd(8'h00, 0);
    op1(8'h06, 8'h00, 0);
    op1(8'h01, 8'hf6, 1);
    srd(8'hf4, 1);
    op1(8'h06, 8'h00, 0);
    mwr(16'h17ff, d[2], d[3]);
    mrd(16'h17ff, d[2], 8'h00, 1);
    op1(8'h06, 8'h00, 0);
    mwr(16'h1fff, d[4], d[5]);
    mrd(16'h1fff, d[0], d[5], 2);
    wg_n = 1'b0;
    op1(8'h06, 8'h00, 0);
    op1(8'h01, 8'h00, 1);
    srd(8'hf4, 0);
    wg_n = 1'b1;
    op1(8'h06, 8'h00, 0);
    op1(8'h04, 8'h00, 0);
    op1(8'h01, 8'h00, 1);
    srd(8'hf4, 0);
    i_mst.sel();
    i_mst.xb(8'h06, 4, 0, 0);
    i_mst.desel();
    op1(8'h01, 8'h00, 1);
    srd(8'hf4, 0);
    op1(8'h06, 8'h00, 0);
    op1(8'h01, 8'h88, 1);
    srd(8'h88, 0);
    op1(8'h06, 8'h00, 0);
    mwr(16'h1fff, d[3], d[4]);
    mrd(16'h1fff, d[0], d[4], 2);
    op1(8'h06, 8'h00, 0);
    op1(8'h01, 8'h0c, 1);
    op1(8'h06, 8'h00, 0);
    mwr(16'h0000, d[1], d[2]);
    mrd(16'h0000, d[4], 8'h00, 1);
    op1(8'h06, 8'h00, 0);
    rst = 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    srd(8'h00, 0);
    stop_test();
  end
endmodule // snv_slave_tb
`default_nettype wire
